// File: common/limit_motion_pkg.sv
// constants, modes and timing for the limit and motion handshake control
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package limit_motion_pkg;

  // operating modes, one-hot
  typedef enum logic [7:0] {
    MODE_POSITION   = 8'h01,
    MODE_RPM        = 8'h02,
    MODE_SCALE_WHOLE = 8'h04,
    MODE_SCALE_FRAC = 8'h08,
    MODE_PRESET     = 8'h10,
    MODE_CHANNEL    = 8'h20,
    MODE_SPEED_HIGH = 8'h40,
    MODE_SPEED_LOW  = 8'h80
  } op_mode_t;

  // output update settings, also the stored code
  typedef enum logic [0:0] {
    CONTINUOUS_UPDATE_SETTING   = 1'h0,
    SYNCHRONIZED_UPDATE_SETTING = 1'h1
  } update_setting_t;

  // timing
  localparam int CLK_HZ         = 25_000_000;
  localparam int SYNC_MIN_US    = 5;
  localparam int SYNC_MAX_US    = 150;
  // cycles per microsecond first, so the products stay inside 32 bits
  localparam int CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int SYNC_MIN_CYC   = SYNC_MIN_US * CYC_PER_US;
  localparam int SYNC_MAX_CYC   = SYNC_MAX_US * CYC_PER_US;
  localparam int TIMER_W        = 12;

  // widths
  localparam int SPEED_W        = 16;
  localparam int POS_W          = 16;
  localparam int BCD_W          = 24;

  // reset values
  localparam logic [SPEED_W-1:0] SPEED_CEIL_RST  = 16'h0BB8;
  localparam logic [SPEED_W-1:0] SPEED_FLOOR_RST = 16'h000A;
  localparam logic [POS_W-1:0]   EDGE_RST        = 16'h0000;
  localparam logic [BCD_W-1:0]   BCD_RST         = 24'h000000;

endpackage

// File: design/sync_refresh_timer.sv
// delay timer that fires one refresh pulse a fixed time after a start pulse
`timescale 1ns/1ns
`default_nettype none
module sync_refresh_timer
  import limit_motion_pkg::*;
#(
  parameter int DELAY_CYC = SYNC_MIN_CYC
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic start,
  output logic      busy,
  output logic      fire
);

  logic [TIMER_W-1:0] count_r;
  logic [TIMER_W-1:0] count_nxt;
  logic               busy_nxt;
  logic               fire_nxt;

  // ----------------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------------
  // a start while busy is ignored so the pending refresh keeps its time
  always_comb begin
    count_nxt = count_r;
    busy_nxt  = busy;
    fire_nxt  = 1'b0;
    if (busy) begin
      if (count_r == TIMER_W'(1)) begin
        busy_nxt = 1'b0;
        fire_nxt = 1'b1;
      end else begin
        count_nxt = count_r - TIMER_W'(1);
      end
    end else if (start) begin
      busy_nxt  = 1'b1;
      count_nxt = TIMER_W'(DELAY_CYC);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count_r <= '0;
      busy    <= 1'b0;
      fire    <= 1'b0;
    end else begin
      count_r <= count_nxt;
      busy    <= busy_nxt;
      fire    <= fire_nxt;
    end
  end

endmodule
`default_nettype wire

// File: design/limit_motion_handshake_control.sv
// output control: channel limit edges, speed window and bcd update handshake
`timescale 1ns/1ns
`default_nettype none
module limit_motion_handshake_control
  import limit_motion_pkg::*;
#(
  parameter int CHANNELS  = 2,
  parameter int DELAY_CYC = SYNC_MIN_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  modeKey,
  input  wire logic                  recallKey,
  input  wire logic                  stepUpKey,
  input  wire logic                  stepDownKey,
  input  wire logic                  programEnable,
  input  wire logic                  shaftMoving,
  input  wire logic [SPEED_W-1:0]    shaftSpeed,
  input  wire logic [POS_W-1:0]      positionCount,
  input  wire logic [BCD_W-1:0]      positionBcd,
  input  wire logic                  hostFreezeInput,
  input  wire logic                  storedSetting,
  output op_mode_t                   displayMode,
  output logic                       showSetting,
  output logic                       edgeSelIsOff,
  output logic [POS_W-1:0]           selectedEdge,
  output logic [SPEED_W-1:0]         speedCeilLimit,
  output logic [SPEED_W-1:0]         speedFloorLimit,
  output logic                       motionOut,
  output logic [CHANNELS-1:0]        channelOut,
  output update_setting_t            updateSetting,
  output logic                       nvWriteStrobe,
  output logic                       nvWriteData,
  output logic [BCD_W-1:0]           bcdOut
);

  localparam int EDGES = 2 * CHANNELS;
  localparam int SEL_W = (EDGES > 1) ? $clog2(EDGES) : 1;

  // rising edge of a key level
  function automatic logic pressed(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // ----------------------------------------------------------------------
  // key edge capture
  // ----------------------------------------------------------------------
  logic [3:0] keyPrev_r;
  logic [3:0] keyPrev_nxt;
  logic       modePress;
  logic       recallPress;
  logic       upPress;
  logic       downPress;
  logic       syncPrev_r;
  logic       syncPrev_nxt;
  logic       syncEdge;
  logic       settingLoaded_r;
  logic       settingLoaded_nxt;

  // key presses and both sync edges as one-cycle events
  always_comb begin
    keyPrev_nxt  = {modeKey, recallKey, stepUpKey, stepDownKey};
    syncPrev_nxt = hostFreezeInput;
    modePress    = pressed(modeKey, keyPrev_r[3]);
    recallPress  = pressed(recallKey, keyPrev_r[2]);
    upPress      = pressed(stepUpKey, keyPrev_r[1]);
    downPress    = pressed(stepDownKey, keyPrev_r[0]);
    syncEdge     = hostFreezeInput ^ syncPrev_r;
    settingLoaded_nxt = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      keyPrev_r       <= 4'hF;
      syncPrev_r      <= 1'b0;
      settingLoaded_r <= 1'b0;
    end else begin
      keyPrev_r       <= keyPrev_nxt;
      syncPrev_r      <= syncPrev_nxt;
      settingLoaded_r <= settingLoaded_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // mode sequencing and programmed values
  // ----------------------------------------------------------------------
  op_mode_t                 mode_nxt;
  logic                     showSetting_nxt;
  logic [SEL_W-1:0]         edgeSel_r;
  logic [SEL_W-1:0]         edgeSel_nxt;
  logic [POS_W-1:0]         edge_r   [EDGES];
  logic [POS_W-1:0]         edge_nxt [EDGES];
  logic [SPEED_W-1:0]       ceil_nxt;
  logic [SPEED_W-1:0]       floor_nxt;
  update_setting_t          setting_nxt;
  logic                     nvStrobe_nxt;
  logic                     step;

  // modes advance on the mode key; steps change values only when enabled
  always_comb begin
    mode_nxt        = displayMode;
    showSetting_nxt = showSetting;
    edgeSel_nxt     = edgeSel_r;
    ceil_nxt        = speedCeilLimit;
    floor_nxt       = speedFloorLimit;
    setting_nxt     = updateSetting;
    nvStrobe_nxt    = 1'b0;
    step            = (upPress | downPress) & programEnable;
    for (int i = 0; i < EDGES; i++) begin
      edge_nxt[i] = edge_r[i];
    end
    if (!settingLoaded_r) begin
      setting_nxt = update_setting_t'(storedSetting);
    end
    if (modePress) begin
      showSetting_nxt = 1'b0;
      case (displayMode)
        MODE_POSITION:    mode_nxt = MODE_RPM;
        MODE_RPM:         mode_nxt = MODE_SCALE_WHOLE;
        MODE_SCALE_WHOLE: mode_nxt = MODE_SCALE_FRAC;
        MODE_SCALE_FRAC:  mode_nxt = MODE_PRESET;
        MODE_PRESET:      mode_nxt = MODE_CHANNEL;
        MODE_CHANNEL:     mode_nxt = MODE_SPEED_HIGH;
        MODE_SPEED_HIGH:  mode_nxt = MODE_SPEED_LOW;
        MODE_SPEED_LOW:   mode_nxt = MODE_POSITION;
        default:          mode_nxt = MODE_POSITION;
      endcase
    end else begin
      case (displayMode)
        MODE_POSITION: begin
          if (recallPress) begin
            showSetting_nxt = 1'b1;
          end else if (showSetting && step) begin
            setting_nxt  = upPress ? SYNCHRONIZED_UPDATE_SETTING
                                   : CONTINUOUS_UPDATE_SETTING;
            nvStrobe_nxt = (setting_nxt != updateSetting);
          end
        end
        MODE_CHANNEL: begin
          if (recallPress) begin
            edgeSel_nxt = (edgeSel_r == SEL_W'(EDGES - 1)) ? '0
                                                           : edgeSel_r + SEL_W'(1);
          end else if (step && !shaftMoving) begin
            if (upPress) begin
              edge_nxt[edgeSel_r] = edge_r[edgeSel_r] + POS_W'(1);
            end else begin
              edge_nxt[edgeSel_r] = edge_r[edgeSel_r] - POS_W'(1);
            end
          end
        end
        MODE_SPEED_HIGH: begin
          if (step && upPress && speedCeilLimit != '1) begin
            ceil_nxt = speedCeilLimit + SPEED_W'(1);
          end else if (step && downPress && speedCeilLimit != '0) begin
            ceil_nxt = speedCeilLimit - SPEED_W'(1);
            if (speedFloorLimit > ceil_nxt) begin
              floor_nxt = ceil_nxt;
            end
          end
        end
        MODE_SPEED_LOW: begin
          if (step && upPress && speedFloorLimit < speedCeilLimit) begin
            floor_nxt = speedFloorLimit + SPEED_W'(1);
          end else if (step && downPress && speedFloorLimit != '0) begin
            floor_nxt = speedFloorLimit - SPEED_W'(1);
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      displayMode     <= MODE_POSITION;
      showSetting     <= 1'b0;
      edgeSel_r       <= '0;
      speedCeilLimit  <= SPEED_CEIL_RST;
      speedFloorLimit <= SPEED_FLOOR_RST;
      updateSetting   <= CONTINUOUS_UPDATE_SETTING;
      nvWriteStrobe   <= 1'b0;
      nvWriteData     <= 1'b0;
      for (int i = 0; i < EDGES; i++) begin
        edge_r[i] <= EDGE_RST;
      end
    end else begin
      displayMode     <= mode_nxt;
      showSetting     <= showSetting_nxt;
      edgeSel_r       <= edgeSel_nxt;
      speedCeilLimit  <= ceil_nxt;
      speedFloorLimit <= floor_nxt;
      updateSetting   <= setting_nxt;
      nvWriteStrobe   <= nvStrobe_nxt;
      nvWriteData     <= setting_nxt;
      for (int i = 0; i < EDGES; i++) begin
        edge_r[i] <= edge_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // channel outputs, speed window and edge view
  // ----------------------------------------------------------------------
  logic [CHANNELS-1:0] channel_nxt;
  logic                motion_nxt;
  logic                edgeOff_nxt;
  logic [POS_W-1:0]    selEdge_nxt;

  // each channel is on from its on edge up to but not at its off edge
  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
      assign channel_nxt[c] = (positionCount >= edge_nxt[2*c]) &&
                              (positionCount <  edge_nxt[2*c+1]);
    end
  endgenerate

  // open window: equality with either limit keeps the output off
  always_comb begin
    motion_nxt  = (shaftSpeed > speedFloorLimit) &&
                  (shaftSpeed < speedCeilLimit);
    edgeOff_nxt = edgeSel_nxt[0];
    selEdge_nxt = edge_nxt[edgeSel_nxt];
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      channelOut   <= '0;
      motionOut    <= 1'b0;
      edgeSelIsOff <= 1'b0;
      selectedEdge <= EDGE_RST;
    end else begin
      channelOut   <= channel_nxt;
      motionOut    <= motion_nxt;
      edgeSelIsOff <= edgeOff_nxt;
      selectedEdge <= selEdge_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // bcd output refresh
  // ----------------------------------------------------------------------
  logic             refreshFire;
  logic [BCD_W-1:0] bcd_nxt;

  sync_refresh_timer #(
    .DELAY_CYC (DELAY_CYC)
  ) u_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (syncEdge && updateSetting == SYNCHRONIZED_UPDATE_SETTING),
    .busy     (),
    .fire     (refreshFire)
  );

  // continuous follows the position; synchronized latches on the timer
  always_comb begin
    bcd_nxt = bcdOut;
    if (updateSetting == CONTINUOUS_UPDATE_SETTING) begin
      bcd_nxt = positionBcd;
    end else if (refreshFire) begin
      bcd_nxt = positionBcd;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bcdOut <= BCD_RST;
    end else begin
      bcdOut <= bcd_nxt;
    end
  end

endmodule
`default_nettype wire

// File: tb/limit_motion_handshake_control_sva.sv
// assertion checker for the limit and motion handshake control
`timescale 1ns/1ns
`default_nettype none
module limit_motion_handshake_control_sva
  import limit_motion_pkg::*;
#(
  parameter int DELAY_CYC = SYNC_MIN_CYC
) (
  input wire logic               core_clk,
  input wire logic               resetn,
  input wire logic               modeKey,
  input wire logic               programEnable,
  input wire logic [SPEED_W-1:0] shaftSpeed,
  input wire logic [BCD_W-1:0]   positionBcd,
  input wire logic               hostFreezeInput,
  input var op_mode_t            displayMode,
  input wire logic [SPEED_W-1:0] speedCeilLimit,
  input wire logic [SPEED_W-1:0] speedFloorLimit,
  input wire logic               motionOut,
  input var update_setting_t     updateSetting,
  input wire logic               nvWriteStrobe,
  input wire logic               nvWriteData,
  input wire logic [BCD_W-1:0]   bcdOut
);
  localparam int RLO = DELAY_CYC + 1;
  localparam int RHI = DELAY_CYC + 4;
  logic [1:0] upHist_r;
  // ----------------------------------------
  // reset history and properties
  // ----------------------------------------
  // bit 0: out of reset last edge, bit 1: last two edges
  always_ff @(posedge core_clk) begin
    upHist_r <= resetn ? {upHist_r[0], 1'b1} : 2'b00;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  a_motion_window: assert property (upHist_r[0] |-> motionOut ==
    ($past(shaftSpeed) > $past(speedFloorLimit) && $past(shaftSpeed) < $past(speedCeilLimit)))
    else $error("motion output wrong for speed");
  a_floor_clamp: assert property (speedFloorLimit <= speedCeilLimit)
    else $error("floor limit above ceiling");
  a_nv_pulse: assert property (nvWriteStrobe |->
    nvWriteData == updateSetting && updateSetting != $past(updateSetting) ##1 !nvWriteStrobe)
    else $error("store strobe wrong");
  a_locked_values: assert property (upHist_r[1] && !$past(programEnable) |->
    $stable(speedCeilLimit) && $stable(speedFloorLimit) && $stable(updateSetting))
    else $error("value changed without program enable");
  a_floor_exit: assert property (upHist_r[1] && $past(modeKey) && !$past(modeKey, 2) &&
    $past(displayMode) == MODE_SPEED_LOW |-> displayMode == MODE_POSITION)
    else $error("floor mode did not return to position");
  a_channel_exit: assert property (upHist_r[1] && $past(modeKey) &&
    !$past(modeKey, 2) && $past(displayMode) == MODE_CHANNEL |-> displayMode == MODE_SPEED_HIGH)
    else $error("channel mode did not advance");
  a_bcd_follow: assert property (upHist_r[0] &&
    $past(updateSetting) == CONTINUOUS_UPDATE_SETTING |-> bcdOut == $past(positionBcd))
    else $error("bcd not following position");
  a_sync_refresh: assert property (upHist_r[0] && $changed(hostFreezeInput) &&
    updateSetting == SYNCHRONIZED_UPDATE_SETTING &&
    $past(updateSetting) == SYNCHRONIZED_UPDATE_SETTING |-> ##[RLO:RHI] bcdOut == $past(positionBcd))
    else $error("bcd not refreshed after sync edge");
endmodule
bind limit_motion_handshake_control limit_motion_handshake_control_sva #(
  .DELAY_CYC(DELAY_CYC)
) checker_i (
  .core_clk(core_clk), .resetn(resetn), .modeKey(modeKey), .programEnable(programEnable),
  .shaftSpeed(shaftSpeed), .positionBcd(positionBcd), .hostFreezeInput(hostFreezeInput),
  .displayMode(displayMode), .speedCeilLimit(speedCeilLimit), .motionOut(motionOut),
  .speedFloorLimit(speedFloorLimit), .updateSetting(updateSetting),
  .nvWriteStrobe(nvWriteStrobe), .nvWriteData(nvWriteData), .bcdOut(bcdOut)
);
`default_nettype wire

// File: tb/host_sync_model.sv
// host controller model: toggles the sync line and reads the bcd word
`timescale 1ns/1ns
`default_nettype none
module host_sync_model
  import limit_motion_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             req,
  input  wire logic [11:0]      holdCyc,
  input  wire logic [BCD_W-1:0] bcdOut,
  output logic                  hostFreezeInput,
  output logic [BCD_W-1:0]      sample,
  output logic                  done
);
  // sync line idles at its last level between transfers
  initial begin
    hostFreezeInput = 1'b0;
    sample = '0;
    done = 1'b0;
  end
  // toggle, wait out the refresh window, then read once
  always begin
    @(posedge core_clk);
    if (req) begin
      hostFreezeInput <= ~hostFreezeInput;
      repeat (int'(holdCyc) + 1) @(posedge core_clk);
      sample <= bcdOut;
      done <= 1'b1;
      @(posedge core_clk);
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_limit_motion_handshake_control.sv
// self-checking bench for the limit and motion handshake control
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module tb_limit_motion_handshake_control
  import limit_motion_pkg::*;
;
  localparam int DLY = 4;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] keys = '0; // mode, recall, up, down
  logic programEnable = 1'b0;
  logic shaftMoving = 1'b0;
  logic req = 1'b0;
  logic stored = 1'b0;
  logic [11:0] holdCyc = 12'hEA7;
  logic [SPEED_W-1:0] shaftSpeed = '0;
  logic [POS_W-1:0] positionCount = '0;
  logic [BCD_W-1:0] positionBcd = '0;
  logic [BCD_W-1:0] bcdOut, sample, last;
  logic hostFreezeInput, done, showSetting, edgeSelIsOff, motionOut, nvWriteStrobe, nvWriteData;
  logic [POS_W-1:0] selectedEdge;
  logic [SPEED_W-1:0] speedCeilLimit, speedFloorLimit;
  logic [1:0] channelOut;
  op_mode_t displayMode, em;
  update_setting_t updateSetting;
  logic [31:0] rnd = 32'h360CBB09;
  logic [SPEED_W-1:0] spdTab [6] = '{16'h0009, 16'h000A, 16'h000B, 16'h0BB7, 16'h0BB8, 16'h0BB9};
  int num_errors = 0;
  int tests_run = 0;
  always #20 core_clk = ~core_clk;
  limit_motion_handshake_control #(.CHANNELS(2), .DELAY_CYC(DLY)) limit_motion_handshake_control_i (
    .core_clk(core_clk), .resetn(resetn), .modeKey(keys[0]), .recallKey(keys[1]),
    .stepUpKey(keys[2]), .stepDownKey(keys[3]), .programEnable(programEnable),
    .shaftMoving(shaftMoving), .shaftSpeed(shaftSpeed), .positionCount(positionCount),
    .positionBcd(positionBcd), .hostFreezeInput(hostFreezeInput), .storedSetting(stored),
    .displayMode(displayMode), .showSetting(showSetting), .edgeSelIsOff(edgeSelIsOff),
    .selectedEdge(selectedEdge), .speedCeilLimit(speedCeilLimit), .motionOut(motionOut),
    .speedFloorLimit(speedFloorLimit), .channelOut(channelOut), .updateSetting(updateSetting),
    .nvWriteStrobe(nvWriteStrobe), .nvWriteData(nvWriteData), .bcdOut(bcdOut));
  host_sync_model host_sync_model_i (.core_clk(core_clk), .req(req), .holdCyc(holdCyc),
    .bcdOut(bcdOut), .hostFreezeInput(hostFreezeInput), .sample(sample), .done(done));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic inWin(input logic [15:0] s, input logic [15:0] f, input logic [15:0] c);
    return s > f && s < c;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one press: high for one sample, then low
  task automatic press(input int k);
    @(posedge core_clk);
    keys[k] <= 1'b1;
    @(posedge core_clk);
    keys[k] <= 1'b0;
    #1;
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int i;
    int w;
    logic [15:0] s;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    tick(2);
    `CHK(displayMode, MODE_POSITION)
    `CHK(speedCeilLimit, SPEED_CEIL_RST)
    `CHK(speedFloorLimit, SPEED_FLOOR_RST)
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      @(posedge core_clk) positionBcd <= rnd[23:0];
      tick(1);
      `CHK(bcdOut, rnd[23:0])
    end
    for (i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      s = (i < 6) ? spdTab[i] : {4'h0, rnd[11:0]};
      @(posedge core_clk) shaftSpeed <= s;
      tick(1);
      `CHK(motionOut, inWin(s, SPEED_FLOOR_RST, SPEED_CEIL_RST))
    end
    em = MODE_POSITION;
    for (i = 0; i < 8; i++) begin
      press(0);
      em = op_mode_t'({em[6:0], em[7]});
      `CHK(displayMode, em)
    end
    repeat (6) press(0);
    press(3);
    `CHK(speedCeilLimit, SPEED_CEIL_RST)
    @(posedge core_clk) programEnable <= 1'b1;
    repeat (2995) press(3);
    `CHK(speedCeilLimit, 16'h0005)
    `CHK(speedFloorLimit, 16'h0005)
    press(0);
    press(2);
    `CHK(speedFloorLimit, 16'h0005)
    press(3);
    `CHK(speedFloorLimit, 16'h0004)
    repeat (6) press(0);
    press(1);
    `CHK(edgeSelIsOff, 1'b1)
    @(posedge core_clk) positionCount <= 16'h0005;
    repeat (10) press(2);
    `CHK(selectedEdge, 16'h000A)
    `CHK(channelOut, 2'b01)
    @(posedge core_clk) shaftMoving <= 1'b1;
    press(2);
    `CHK(selectedEdge, 16'h000A)
    @(posedge core_clk);
    shaftMoving <= 1'b0;
    positionCount <= 16'h0009;
    press(3);
    `CHK(channelOut, 2'b00)
    press(0);
    `CHK(displayMode, MODE_SPEED_HIGH)
    repeat (2) press(0);
    press(1);
    `CHK(showSetting, 1'b1)
    press(2);
    `CHK(updateSetting, SYNCHRONIZED_UPDATE_SETTING)
    `CHK({nvWriteStrobe, nvWriteData}, 2'b11)
    tick(1);
    `CHK(nvWriteStrobe, 1'b0)
    last = positionBcd;
    for (i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      @(posedge core_clk) positionBcd <= rnd[23:0];
      req <= 1'b1;
      holdCyc <= i ? 12'hFA0 : 12'hEA7;
      @(posedge core_clk) req <= 1'b0;
      tick(2);
      `CHK(bcdOut, last)
      for (w = 0; w < 5000 && done !== 1'b1; w++) tick(1);
      if (w == 5000) begin
        num_errors++;
        $display("ERROR %0t host read timed out", $time);
        break;
      end
      `CHK(sample, rnd[23:0])
      last = rnd[23:0];
      @(posedge core_clk) positionBcd <= ~last;
      tick(20);
      `CHK(bcdOut, last)
    end
    press(3);
    `CHK({updateSetting, nvWriteStrobe, nvWriteData}, 3'b010)
    tick(2);
    `CHK(bcdOut, positionBcd)
    // mid-run reset: the stored setting comes back, with no store strobe
    @(posedge core_clk);
    resetn <= 1'b0;
    stored <= 1'b1;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    tick(2);
    `CHK({updateSetting, nvWriteStrobe}, 2'b10)
    print_verdict();
  end
endmodule
`default_nettype wire
